//--- include/pwr_rst_pkg.sv
package pwr_rst_pkg;

  // Clock period of clk_i, in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Minimum reset hold, in oscillator clock periods
  localparam int unsigned RST_HOLD_CLKS = 24;
  localparam logic [7:0] RST_HOLD_CNT = 8'(RST_HOLD_CLKS);

  // Watchdog reset pulse, in oscillator clock periods
  localparam int unsigned WDT_PULSE_CLKS = 96;
  localparam logic [7:0] WDT_PULSE_CNT = 8'(WDT_PULSE_CLKS);

  // Keyboard wake restart count, in oscillator clock periods
  localparam int unsigned KBD_RESTART_CLKS = 1024;
  localparam logic [10:0] KBD_RESTART_CNT = 11'(KBD_RESTART_CLKS);

  // Program counter value forced by reset
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Wishbone byte addresses
  localparam logic [7:0] ADDR_PWR_CTL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;

  // Power control register field positions
  localparam int unsigned BIT_IDLE = 0;
  localparam int unsigned BIT_PWRDN = 1;
  localparam int unsigned BIT_FLAG0 = 2;
  localparam int unsigned BIT_FLAG1 = 3;
  localparam logic [3:0] PWR_CTL_RESET = 4'h0;

  // Configuration register fields
  localparam int unsigned BIT_KBD_LVL = 0;
  localparam int unsigned BIT_KBD_EN = 4;
  localparam int unsigned BIT_INT_EN = 8;
  localparam logic [9:0] CFG_RESET = 10'h000;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_IDLE = 5'h02,
    ST_PWRDN = 5'h04,
    ST_WAIT_INT = 5'h08,
    ST_WAIT_KBD = 5'h10
  } pwr_state_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic per_clk_en;
    logic osc_en;
    logic core_rst;
    logic ram_block;
    logic pins_float;
    logic pins_high;
    logic pins_hold;
  } pwr_ctl_t;

endpackage

//--- rtl/power_mode_reset_control.sv
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Valid reset initialises registers and forces program counter to zero.
// - Watchdog expiry drives a 96-clock reset pulse onto the reset pin.
// - During reset, port 0 and card pins float, ports 1-5 driven high.
// - In idle and power-down, all pins hold their last data.
// - Reset loads boot mapping enable from the configuration bit.
// - Idle gates CPU clock; peripherals run; CPU state retained.
// - Setting idle bit enters idle after the setting instruction.
// - Idle and power-down set together gives power-down only, no later idle.
// - Enabled interrupt in idle clears idle bit and restores CPU clock.
// - Two general flag bits, software writable, beside mode bits.
// - Reset pin high clears idle bit at once and restores CPU clock.
// - Between reset wake and internal reset, RAM blocked, ports allowed.
// - Power-down stops oscillator and freezes all clocks, state retained.
// - Setting power-down bit enters power-down after the setting instruction.
// - Enabled external or keyboard wake clears power-down bit, restarts clocks.
// - External interrupt wake holds CPU until the line is released.
// - Keyboard wake waits 1024 clocks before execution resumes.
// - Keyboard wake lines trigger on selectable high or low level.
// - External interrupt wake keeps registers and RAM unchanged.
// - Reset pin high clears power-down bit and restarts oscillator.
// - Power-down at bit 1, idle at bit 0, reset zero, power-down wins.
module power_mode_reset_control (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins and sources
  input wire logic rst_pin_i,
  input wire logic wdt_expire_i,
  input wire logic boot_jump_config_bit_i,
  input wire logic ext_interrupt_zero_i,
  input wire logic ext_interrupt_one_i,
  input wire logic [3:0] keyboard_wake_lines_i,
  input wire logic irq_pending_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n_o,
  // Core side
  output logic [15:0] pc_load_o,
  output logic pc_load_en_o,
  output logic boot_map_enable_o,
  output logic cpu_clk_en_o,
  output logic per_clk_en_o,
  output logic osc_en_o,
  output logic core_rst_o,
  output logic ram_block_o,
  output logic pins_float_o,
  output logic pins_high_o,
  output logic pins_hold_o
);

  // Pin synchronisers
  logic [1:0] rst_sync_ff;
  logic [1:0] ext0_sync_ff;
  logic [1:0] ext1_sync_ff;
  logic [3:0] kbd_sync0_ff;
  logic [3:0] kbd_sync1_ff;
  logic rst_pin_s, ext0_s, ext1_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_sync_ff <= 2'h0;
      ext0_sync_ff <= 2'h0;
      ext1_sync_ff <= 2'h0;
      kbd_sync0_ff <= 4'h0;
      kbd_sync1_ff <= 4'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], rst_pin_i};
      ext0_sync_ff <= {ext0_sync_ff[0], ext_interrupt_zero_i};
      ext1_sync_ff <= {ext1_sync_ff[0], ext_interrupt_one_i};
      kbd_sync0_ff <= keyboard_wake_lines_i;
      kbd_sync1_ff <= kbd_sync0_ff;
    end
  end

  assign rst_pin_s = rst_sync_ff[1];
  assign ext0_s = ext0_sync_ff[1];
  assign ext1_s = ext1_sync_ff[1];

  // Registers
  logic [3:0] pwr_ctl_ff;
  logic [9:0] cfg_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic wr_pwr_ctl, wr_cfg, req;
  logic boot_map_ff;

  assign req = cyc_i && stb_i && !ack_ff;
  assign wr_pwr_ctl = req && we_i && sel_i[0] && (adr_i == pwr_rst_pkg::ADDR_PWR_CTL);
  assign wr_cfg = req && we_i && (adr_i == pwr_rst_pkg::ADDR_CFG);

  // Watchdog pulse driven onto the reset pin
  logic [7:0] wdt_cnt_ff;
  logic wdt_drive;
  assign wdt_drive = (wdt_cnt_ff != 8'h00);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_cnt_ff <= 8'h00;
    end else if (wdt_expire_i && !wdt_drive) begin
      wdt_cnt_ff <= pwr_rst_pkg::WDT_PULSE_CNT;
    end else if (wdt_drive) begin
      wdt_cnt_ff <= wdt_cnt_ff - 8'h01;
    end
  end

  // Reset level seen by the block: pin or own watchdog pulse
  logic rst_level;
  assign rst_level = rst_pin_s || wdt_drive;

  // Hold counter; internal reset only once the pin held long enough
  logic [7:0] hold_cnt_ff;
  logic core_rst_ff;
  logic hold_met;
  assign hold_met = (hold_cnt_ff >= pwr_rst_pkg::RST_HOLD_CNT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_cnt_ff <= 8'h00;
    end else if (!rst_level) begin
      hold_cnt_ff <= 8'h00;
    end else if (!hold_met) begin
      hold_cnt_ff <= hold_cnt_ff + 8'h01;
    end
  end

  // Internal reset asserts once hold met, releases when level drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_rst_ff <= 1'b1;
    end else if (rst_level && hold_met) begin
      core_rst_ff <= 1'b1;
    end else if (!rst_level) begin
      core_rst_ff <= 1'b0;
    end
  end

  // Power mode state machine
  pwr_rst_pkg::pwr_state_t state_ff, nxt_state;
  logic [10:0] kbd_cnt_ff;
  logic [3:0] kbd_hit;
  logic int_wake, kbd_wake;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_kbd
      // Level select per line
      assign kbd_hit[gi] = cfg_ff[pwr_rst_pkg::BIT_KBD_EN + gi] &&
        (kbd_sync1_ff[gi] == cfg_ff[pwr_rst_pkg::BIT_KBD_LVL + gi]);
    end
  endgenerate

  assign int_wake = (cfg_ff[pwr_rst_pkg::BIT_INT_EN] && ext0_s) ||
    (cfg_ff[pwr_rst_pkg::BIT_INT_EN + 1] && ext1_s);
  assign kbd_wake = |kbd_hit;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pwr_rst_pkg::ST_RUN: begin
        if (pwr_ctl_ff[pwr_rst_pkg::BIT_PWRDN]) begin
          nxt_state = pwr_rst_pkg::ST_PWRDN;
        end else if (pwr_ctl_ff[pwr_rst_pkg::BIT_IDLE]) begin
          nxt_state = pwr_rst_pkg::ST_IDLE;
        end
      end
      pwr_rst_pkg::ST_IDLE: begin
        if (rst_level || irq_pending_i) begin
          nxt_state = pwr_rst_pkg::ST_RUN;
        end
      end
      pwr_rst_pkg::ST_PWRDN: begin
        if (rst_level) begin
          nxt_state = pwr_rst_pkg::ST_RUN;
        end else if (int_wake) begin
          nxt_state = pwr_rst_pkg::ST_WAIT_INT;
        end else if (kbd_wake) begin
          nxt_state = pwr_rst_pkg::ST_WAIT_KBD;
        end
      end
      pwr_rst_pkg::ST_WAIT_INT: begin
        if (rst_level || !int_wake) begin
          nxt_state = pwr_rst_pkg::ST_RUN;
        end
      end
      pwr_rst_pkg::ST_WAIT_KBD: begin
        if (rst_level || kbd_cnt_ff == 11'h000) begin
          nxt_state = pwr_rst_pkg::ST_RUN;
        end
      end
      default: nxt_state = pwr_rst_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= pwr_rst_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kbd_cnt_ff <= 11'h000;
    end else if (state_ff == pwr_rst_pkg::ST_PWRDN) begin
      kbd_cnt_ff <= pwr_rst_pkg::KBD_RESTART_CNT - 11'h001;
    end else if (state_ff == pwr_rst_pkg::ST_WAIT_KBD && kbd_cnt_ff != 11'h000) begin
      kbd_cnt_ff <= kbd_cnt_ff - 11'h001;
    end
  end

  // Power control register; hardware clears beat software sets, except the run-state idle clear under power-down
  logic pwr_ctl_clr;
  assign pwr_ctl_clr = rst_level || core_rst_ff ||
    (state_ff == pwr_rst_pkg::ST_IDLE && irq_pending_i) ||
    (state_ff == pwr_rst_pkg::ST_PWRDN && (int_wake || kbd_wake));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_ctl_ff <= pwr_rst_pkg::PWR_CTL_RESET;
    end else begin
      if (core_rst_ff) begin
        pwr_ctl_ff[pwr_rst_pkg::BIT_FLAG1:pwr_rst_pkg::BIT_FLAG0] <= 2'h0;
      end else if (wr_pwr_ctl) begin
        pwr_ctl_ff[pwr_rst_pkg::BIT_FLAG1:pwr_rst_pkg::BIT_FLAG0] <= dat_i[3:2];
      end
      if (pwr_ctl_clr) begin
        pwr_ctl_ff[pwr_rst_pkg::BIT_PWRDN:pwr_rst_pkg::BIT_IDLE] <= 2'h0;
      end else if (wr_pwr_ctl && state_ff == pwr_rst_pkg::ST_RUN) begin
        pwr_ctl_ff[pwr_rst_pkg::BIT_PWRDN:pwr_rst_pkg::BIT_IDLE] <= dat_i[1:0];
      end else if (state_ff == pwr_rst_pkg::ST_RUN && pwr_ctl_ff[pwr_rst_pkg::BIT_PWRDN]) begin
        pwr_ctl_ff[pwr_rst_pkg::BIT_IDLE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || core_rst_ff) begin
      cfg_ff <= pwr_rst_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_ff <= dat_i[9:0];
    end
  end

  // Bus answer: registered ack one cycle after the strobe, zero for unmapped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (req && !we_i) begin
        if (adr_i == pwr_rst_pkg::ADDR_PWR_CTL) begin
          dat_ff <= {28'h0000000, pwr_ctl_ff};
        end else if (adr_i == pwr_rst_pkg::ADDR_CFG) begin
          dat_ff <= {22'h000000, cfg_ff};
        end else if (adr_i == pwr_rst_pkg::ADDR_STAT) begin
          dat_ff <= {25'h0000000, core_rst_ff, boot_map_ff, state_ff};
        end else begin
          dat_ff <= 32'h0000_0000;
        end
      end
    end
  end

  // Boot map caught from the strap while internal reset is active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_map_ff <= 1'b0;
    end else if (core_rst_ff) begin
      boot_map_ff <= boot_jump_config_bit_i;
    end
  end

  // Control outputs; all registered
  pwr_rst_pkg::pwr_ctl_t ctl_ff, nxt_ctl;
  logic wake_by_rst;
  assign wake_by_rst = rst_level && !core_rst_ff;

  always_comb begin
    nxt_ctl = '0;
    nxt_ctl.core_rst = core_rst_ff || (rst_level && hold_met);
    nxt_ctl.osc_en = (nxt_state != pwr_rst_pkg::ST_PWRDN);
    nxt_ctl.per_clk_en = nxt_ctl.osc_en;
    nxt_ctl.cpu_clk_en = (nxt_state == pwr_rst_pkg::ST_RUN);
    // Pins keep last data in low-power states
    nxt_ctl.pins_hold = !nxt_ctl.cpu_clk_en && !nxt_ctl.core_rst;
    nxt_ctl.pins_float = nxt_ctl.core_rst;
    nxt_ctl.pins_high = nxt_ctl.core_rst;
    // RAM is off limits while reset wake runs ahead of internal reset
    nxt_ctl.ram_block = wake_by_rst && !nxt_ctl.core_rst;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_ff <= '{cpu_clk_en: 1'b0, per_clk_en: 1'b1, osc_en: 1'b1, core_rst: 1'b1,
        ram_block: 1'b0, pins_float: 1'b1, pins_high: 1'b1, pins_hold: 1'b0};
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  logic pc_load_ff, rst_pin_drv_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_load_ff <= 1'b1;
      rst_pin_drv_ff <= 1'b0;
    end else begin
      pc_load_ff <= nxt_ctl.core_rst;
      // Pin high from the load cycle for exactly the pulse count
      rst_pin_drv_ff <= (wdt_expire_i && !wdt_drive) ||
        (wdt_drive && wdt_cnt_ff != 8'h01);
    end
  end

  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  assign rst_pin_o = rst_pin_drv_ff;
  assign rst_pin_oe_n_o = !rst_pin_drv_ff;
  assign pc_load_o = pwr_rst_pkg::RESET_VECTOR;
  assign pc_load_en_o = pc_load_ff;
  assign boot_map_enable_o = boot_map_ff;
  assign cpu_clk_en_o = ctl_ff.cpu_clk_en;
  assign per_clk_en_o = ctl_ff.per_clk_en;
  assign osc_en_o = ctl_ff.osc_en;
  assign core_rst_o = ctl_ff.core_rst;
  assign ram_block_o = ctl_ff.ram_block;
  assign pins_float_o = ctl_ff.pins_float;
  assign pins_high_o = ctl_ff.pins_high;
  assign pins_hold_o = ctl_ff.pins_hold;

  // Checks
  AST_WDT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wdt_drive) |-> wdt_drive [*8] ##0 (wdt_cnt_ff == 8'h59))
    else $error("watchdog pulse too short");
  AST_RST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(core_rst_ff) |-> $past(hold_met))
    else $error("internal reset before hold count");
  AST_PD_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_rst_pkg::ST_RUN && pwr_ctl_ff[1] && !rst_level) |=>
    state_ff == pwr_rst_pkg::ST_PWRDN)
    else $error("power-down not taken");
  AST_IDLE_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_rst_pkg::ST_RUN && pwr_ctl_ff == 4'h1) |=> state_ff == pwr_rst_pkg::ST_IDLE)
    else $error("idle not entered");
  AST_IDLE_EXIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_rst_pkg::ST_IDLE && irq_pending_i) |=> ##1 cpu_clk_en_o && !pwr_ctl_ff[0])
    else $error("idle exit failed");
  AST_OSC_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == pwr_rst_pkg::ST_PWRDN |=> !osc_en_o || state_ff != pwr_rst_pkg::ST_PWRDN)
    else $error("oscillator runs in power-down");
  AST_INT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_rst_pkg::ST_WAIT_INT && int_wake && !rst_level) |=> !cpu_clk_en_o)
    else $error("cpu ran before line released");
  AST_KBD_WAIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == pwr_rst_pkg::ST_WAIT_KBD && kbd_cnt_ff > 11'h1 && !rst_level) |=>
    state_ff == pwr_rst_pkg::ST_WAIT_KBD)
    else $error("keyboard restart cut short");
  AST_RST_PINS: assert property (@(posedge clk_i) disable iff (rst_i)
    core_rst_o |-> pins_float_o && pins_high_o)
    else $error("pin states wrong in reset");
  COV_IDLE: cover property (@(posedge clk_i) state_ff == pwr_rst_pkg::ST_IDLE);
  COV_KBD: cover property (@(posedge clk_i) state_ff == pwr_rst_pkg::ST_WAIT_KBD);
  COV_INT: cover property (@(posedge clk_i) state_ff == pwr_rst_pkg::ST_WAIT_INT);
  COV_WDT: cover property (@(posedge clk_i) $rose(wdt_drive));

endmodule // power_mode_reset_control

`default_nettype wire

//--- verif/wake_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
  input wire logic clk_i,
  input wire logic rst_go_i,
  input wire logic [7:0] rst_len_i,
  input wire logic [1:0] ext_hold_i,
  input wire logic [3:0] kbd_i,
  input wire logic irq_go_i,
  input wire logic cpu_clk_en_i,
  input wire logic dev_pin_i,
  input wire logic dev_pin_oe_n_i,
  output logic pin_level_o,
  output logic ext_zero_o,
  output logic ext_one_o,
  output logic [3:0] kbd_o,
  output logic irq_pending_o
);
  logic [7:0] hold_ff = 8'h00;
  logic [1:0] run_ff = 2'h0;
  logic pend_ff = 1'b0;
  always_ff @(posedge clk_i) begin
    if (rst_go_i) begin
      hold_ff <= rst_len_i;
    end else if (hold_ff != 8'h00) begin
      hold_ff <= hold_ff - 8'h01;
    end
  end
  // Pull-down wins when neither side drives the pin
  assign pin_level_o = (hold_ff != 8'h00) | (~dev_pin_oe_n_i & dev_pin_i);
  // Levels stay until the bench lets go, long enough for restart
  assign ext_zero_o = ext_hold_i[0];
  assign ext_one_o = ext_hold_i[1];
  assign kbd_o = kbd_i;
  // Core keeps the request until it has clocked through to the vector
  always_ff @(posedge clk_i) begin
    if (irq_go_i) begin
      pend_ff <= 1'b1;
    end else if (run_ff == 2'h3) begin
      pend_ff <= 1'b0;
    end
    run_ff <= (pend_ff && cpu_clk_en_i) ? {run_ff[0], 1'b1} : 2'h0;
  end
  assign irq_pending_o = pend_ff;
endmodule // wake_source_model
`default_nettype wire

//--- verif/power_mode_reset_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_control_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic wdt_i = 1'b0;
  logic strap = 1'b0;
  logic rst_go = 1'b0;
  logic [7:0] rst_len = 8'h00;
  logic [1:0] ext_hold = 2'h0;
  logic [3:0] kbd = 4'hF;
  logic irq_go = 1'b0;
  logic [31:0] dat_o, cfg, gf;
  logic ack_o, pin_lvl, ext0, ext1, irq_w, rst_pin_o, rst_pin_oe_n_o, pc_load_en_o, boot_o;
  logic cpu_o, per_o, osc_o, core_rst_o, ram_block_o, float_o, high_o, hold_o;
  logic [3:0] kbd_w;
  logic [15:0] pc_load_o;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 33;
  int n, k, r, lv;
  logic [31:0] exp_q[$];

  power_mode_reset_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rst_pin_i(pin_lvl), .wdt_expire_i(wdt_i), .boot_jump_config_bit_i(strap),
    .ext_interrupt_zero_i(ext0), .ext_interrupt_one_i(ext1), .keyboard_wake_lines_i(kbd_w),
    .irq_pending_i(irq_w), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o),
    .pc_load_o(pc_load_o), .pc_load_en_o(pc_load_en_o), .boot_map_enable_o(boot_o),
    .cpu_clk_en_o(cpu_o), .per_clk_en_o(per_o), .osc_en_o(osc_o), .core_rst_o(core_rst_o),
    .ram_block_o(ram_block_o), .pins_float_o(float_o), .pins_high_o(high_o),
    .pins_hold_o(hold_o));

  wake_source_model far (.clk_i(clk_i), .rst_go_i(rst_go), .rst_len_i(rst_len),
    .ext_hold_i(ext_hold), .kbd_i(kbd), .irq_go_i(irq_go), .cpu_clk_en_i(cpu_o),
    .dev_pin_i(rst_pin_o), .dev_pin_oe_n_i(rst_pin_oe_n_o), .pin_level_o(pin_lvl),
    .ext_zero_o(ext0), .ext_one_o(ext1), .kbd_o(kbd_w), .irq_pending_o(irq_w));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads queue their expectation; the watcher below compares at ack
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && t < 20) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 20) begin
      n_fail++;
      $display("wrong value at %0t: bus never answered", $time);
      tally_and_finish();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("wrong value at %0t: read answer nobody asked for", $time);
      end else begin
        chk(dat_o, exp_q.pop_front());
      end
    end
  end

  function automatic logic sig(input int w);
    case (w)
      0: return cpu_o;
      1: return osc_o;
      2: return core_rst_o;
      default: return rst_pin_o;
    endcase
  endfunction

  // Edges counted into n; running out of bound ends the run
  task automatic wait_sig(input int w, input logic lvl, input int lim);
    n = 0;
    while (sig(w) !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      n_fail++;
      $display("wrong value at %0t: wait %0d timed out", $time, w);
      tally_and_finish();
    end
  endtask

  task automatic pin_pulse(input logic [7:0] len);
    rst_len <= len;
    rst_go <= 1'b1;
    @(posedge clk_i);
    rst_go <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    $display("wrong value at %0t: run too long", $time);
    tally_and_finish();
  end

  initial begin
    r = $random(seed);
    strap = r[0];
    repeat (8) @(posedge clk_i);
    chk(32'({float_o, high_o, core_rst_o, pc_load_en_o, cpu_o}), 32'h1E);
    chk(32'(pc_load_o), 32'(pwr_rst_pkg::RESET_VECTOR));
    rst_i <= 1'b0;
    @(posedge clk_i);
    wait_sig(2, 1'b0, 20);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h01 | (32'(strap) << 5));
    chk(32'(boot_o), 32'(strap));
    rd(8'h0C, 32'h0);
    r = $random(seed);
    gf = {28'h0, r[3:2], 2'h0};
    wb(1'b1, 8'h00, gf);
    rd(8'h00, gf);
    wb(1'b1, 8'h00, gf | 32'h1);
    wait_sig(0, 1'b0, 3);
    chk(32'({per_o, osc_o, hold_o}), 32'h7);
    irq_go <= 1'b1;
    @(posedge clk_i);
    irq_go <= 1'b0;
    wait_sig(0, 1'b1, 6);
    rd(8'h00, gf);
    r = $random(seed);
    wb(1'b1, 8'h04, 32'h100 << r[0]);
    wb(1'b1, 8'h00, gf | 32'h3);
    wait_sig(1, 1'b0, 4);
    chk(32'({cpu_o, per_o, hold_o}), 32'h1);
    ext_hold <= 2'h1 << r[0];
    wait_sig(1, 1'b1, 10);
    repeat (20) @(posedge clk_i);
    chk(32'(cpu_o), 32'h0);
    ext_hold <= 2'h0;
    wait_sig(0, 1'b1, 10);
    rd(8'h00, gf);
    rd(8'h08, 32'h01 | (32'(strap) << 5));
    for (lv = 0; lv < 2; lv++) begin
      r = $random(seed);
      k = r[1:0];
      cfg = (32'h10 << k) | (32'(lv) << k);
      kbd <= ~cfg[3:0];
      wb(1'b1, 8'h04, cfg);
      wb(1'b1, 8'h00, 32'h2);
      wait_sig(1, 1'b0, 4);
      kbd[k] <= lv[0];
      wait_sig(1, 1'b1, 10);
      wait_sig(0, 1'b1, 1100);
      chk(32'(n >= 1024 && n <= 1040), 32'h1);
      kbd[k] <= ~lv[0];
      @(posedge clk_i);
    end
    // Short pin pulse: wakes idle but is too brief for a full reset
    wb(1'b1, 8'h00, gf | 32'h1);
    wait_sig(0, 1'b0, 3);
    pin_pulse(8'h0A);
    wait_sig(0, 1'b1, 8);
    r = 0;
    repeat (40) begin
      @(posedge clk_i);
      r = r | 32'(core_rst_o);
    end
    chk(32'(r), 32'h0);
    rd(8'h00, gf);
    wb(1'b1, 8'h00, gf | 32'h2);
    wait_sig(1, 1'b0, 4);
    pin_pulse(8'h1E);
    repeat (7) @(posedge clk_i);
    chk(32'({osc_o, cpu_o, ram_block_o, core_rst_o}), 32'hE);
    wait_sig(2, 1'b1, 30);
    chk(32'(n >= 16), 32'h1);
    chk(32'({pc_load_en_o, float_o, high_o}), 32'h7);
    wait_sig(2, 1'b0, 40);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    wdt_i <= 1'b1;
    @(posedge clk_i);
    wdt_i <= 1'b0;
    wait_sig(3, 1'b1, 4);
    r = 0;
    while (rst_pin_o === 1'b1 && r < 200) begin
      chk(32'({rst_pin_oe_n_o, core_rst_o}), 32'(r > pwr_rst_pkg::RST_HOLD_CLKS));
      @(posedge clk_i);
      r++;
    end
    chk(32'(r), 32'(pwr_rst_pkg::WDT_PULSE_CLKS));
    wait_sig(2, 1'b0, 40);
    rd(8'h08, 32'h01 | (32'(strap) << 5));
    tally_and_finish();
  end
endmodule // power_mode_reset_control_bench
`default_nettype wire
